// ==== hdl/rmc_pkg.sv ====
// Package for the modem control port: timing counts, frame shape and state codes.
// Assumes a single 100 MHz reference clock.
package rmc_pkg;

    // Reference clock period in picoseconds (10 ns).
    localparam int unsigned CLK_PERIOD_PS   = 10000;
    // Default bit rate in bits per second, the least rate the link must offer.
    localparam int unsigned BAUD_MIN_BPS    = 19200;
    // Highest bit rate that may be configured.
    localparam int unsigned BAUD_MAX_BPS    = 1000000;
    // Reference clock rate derived from the period.
    localparam int unsigned CLK_HZ          = 32'(64'd1000000000000 / CLK_PERIOD_PS);
    // Clock cycles per bit at the least rate, rounded down.
    localparam int unsigned DIV_DEFAULT     = CLK_HZ / BAUD_MIN_BPS;
    // Clock cycles per bit at the highest rate.
    localparam int unsigned DIV_MIN         = CLK_HZ / BAUD_MAX_BPS;
    // Width of the bit-period divider.
    localparam int unsigned DIV_W           = 16;
    // Receive oversampling: ticks per bit.
    localparam int unsigned OVS             = 16;
    // Data bits per character.
    localparam int unsigned DATA_W          = 8;
    // Reset level of data pins: line idle is mark, logic 1.
    localparam logic        IDLE_LEVEL      = 1'b1;

    // Transmit state machine, one-hot codes.
    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } rmc_tx_state_t;

    // Receive state machine, one-hot codes.
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rmc_rx_state_t;

endpackage

// ==== hdl/rmc_rx.sv ====
// Receiver of the modem control port: one character framed by start and stop bit.
// Assumes rx_bit is already synchronised and a tick pulse of 16 per bit period.
`timescale 1ns/10ps
`default_nettype none

module rmc_rx
    import rmc_pkg::*;
(
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // Oversampling tick and line.
    input  wire logic              tick,
    input  wire logic              rx_bit,
    // Received character.
    output logic [DATA_W-1:0]      data,
    output logic                   valid,
    output logic                   frame_err
);

    rmc_rx_state_t     st_q;
    logic [3:0]        os_q;
    logic [2:0]        bit_q;
    logic [DATA_W-1:0] sh_q;
    logic              prev_q;

    // Sample point is the middle of each bit.
    wire mid_w  = tick && (os_q == 4'(OVS/2 - 1));
    wire last_w = tick && (os_q == 4'(OVS - 1));

    // Start bit hunt, mid-bit sampling and stop bit check.
    always_ff @(posedge ref_clk) begin
        valid <= 1'b0;
        if (sys_rst) begin
            st_q      <= RX_IDLE;
            os_q      <= 4'h0;
            bit_q     <= 3'h0;
            sh_q      <= '0;
            data      <= '0;
            frame_err <= 1'b0;
            prev_q    <= IDLE_LEVEL;
        end else begin
            prev_q <= rx_bit;
            if (tick) begin
                os_q <= os_q + 4'h1;
            end
            case (st_q)
                RX_IDLE: begin
                    os_q <= 4'h0;
                    if (prev_q && !rx_bit) begin // A line held low after a bad stop bit waits.
                        st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (mid_w) begin
                        st_q <= rx_bit ? RX_IDLE : RX_START; // Glitch rejects start.
                    end
                    if (last_w) begin
                        st_q  <= RX_DATA;
                        bit_q <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (mid_w) begin
                        sh_q <= {rx_bit, sh_q[DATA_W-1:1]}; // LSB first.
                    end
                    if (last_w) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (mid_w) begin
                        data      <= sh_q;
                        valid     <= 1'b1;
                        frame_err <= !rx_bit;
                        st_q      <= RX_IDLE;
                    end
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end

endmodule // rmc_rx

`default_nettype wire

// ==== hdl/rmc_port.sv ====
// Host-end modem control port: serial data both ways plus the modem handshake lines.
// Assumes one 100 MHz clock; pins are logic levels after the line transceiver,
// which performs the voltage inversion.
//
// What this block does
// - Host drives outgoing serial data on the transmit-data pin toward the modem.
// - Transmit and receive run independently and at the same time.
// - Request-to-send is asserted while a character is queued to send.
// - With flow control on, no character starts until clear-to-send is seen.
// - Terminal-ready is asserted when the host is ready to move data.
// - A ring indication makes the host assert terminal-ready.
// - Line levels are inverted in the transceiver, not here: negative voltage is 1, positive is 0.
// - Bit rate is configurable, at least 19.2 kbit/s, up to 1 Mbit/s.
`timescale 1ns/10ps
`default_nettype none

module rmc_port
    import rmc_pkg::*;
(
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // Configuration.
    input  wire logic [DIV_W-1:0]  bit_div,
    input  wire logic              flow_en,
    input  wire logic              host_ready,
    // Transmit request.
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    // Received characters.
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   rx_frame_err,
    // Modem status seen by the host.
    output logic                   dsr_seen,
    output logic                   dcd_seen,
    output logic                   ri_seen,
    output logic                   cts_seen,
    // Line pins, logic level.
    output logic                   td,
    input  wire logic              rd,
    output logic                   rts,
    input  wire logic              cts,
    output logic                   dtr,
    input  wire logic              dsr,
    input  wire logic              dcd,
    input  wire logic              ri
);

    // Three-stage synchronisers for all five input pins.
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [4:0] stab_q;
    wire  [4:0] pins_w = {ri, dcd, dsr, cts, rd};
    wire  [4:0] agree_w;

    // Per-pin agreement of stages two and three.
    for (genvar g = 0; g < 5; g++) begin : g_agree
        assign agree_w[g] = (s2_q[g] == s3_q[g]);
    end

    // Pin sampling; a change counts once stages two and three agree.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_q   <= 5'h01;
            s2_q   <= 5'h01;
            s3_q   <= 5'h01;
            stab_q <= 5'h01;
        end else begin
            s1_q <= pins_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= (s3_q & agree_w) | (stab_q & ~agree_w);
        end
    end

    // Named synchronised levels; inversion lives in the transceiver.
    wire rd_w  = stab_q[0];
    wire cts_w = stab_q[1];
    wire dsr_w = stab_q[2];
    wire dcd_w = stab_q[3];
    wire ri_w  = stab_q[4];

    // Bit-rate divider; clamped to no fewer than DIV_MIN cycles, the divider of the highest allowed rate.
    wire [DIV_W-1:0] div_w  = (bit_div < DIV_W'(DIV_MIN)) ? DIV_W'(DIV_MIN) : bit_div;
    wire [DIV_W-1:0] tdiv_w = div_w >> 4;
    logic [DIV_W-1:0] tcnt_q;
    logic             tick_q;

    // Oversampling tick at sixteen per bit.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || tcnt_q >= tdiv_w - DIV_W'(1)) begin
            tcnt_q <= '0;
            tick_q <= !sys_rst;
        end else begin
            tcnt_q <= tcnt_q + DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    // Receiver runs on its own state, independent of transmit.
    rmc_rx u_rx (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .tick      (tick_q),
        .rx_bit    (rd_w),
        .data      (rx_data),
        .valid     (rx_valid),
        .frame_err (rx_frame_err)
    );

    // Transmitter state and one-character holding register.
    rmc_tx_state_t     tst_q;
    logic [DATA_W-1:0] hold_q;
    logic              full_q;
    logic [DATA_W-1:0] tsh_q;
    logic [3:0]        tos_q;
    logic [2:0]        tbit_q;

    wire take_w   = tx_valid && !full_q;
    wire go_w     = full_q && (!flow_en || cts_w);
    wire bend_w   = tick_q && (tos_q == 4'(OVS - 1));
    wire load_w   = (tst_q == TX_IDLE) && go_w;

    // Holding register accepts one character at a time.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            full_q <= 1'b0;
            hold_q <= '0;
        end else if (load_w) begin
            full_q <= 1'b0;
        end else if (take_w) begin
            full_q <= 1'b1;
            hold_q <= tx_data;
        end
    end

    // Transmit framing: start bit, eight data bits LSB first, one stop bit.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tst_q  <= TX_IDLE;
            tsh_q  <= '0;
            tos_q  <= 4'h0;
            tbit_q <= 3'h0;
            td     <= IDLE_LEVEL;
        end else begin
            if (tick_q) begin
                tos_q <= tos_q + 4'h1;
            end
            case (tst_q)
                TX_IDLE: begin
                    td    <= IDLE_LEVEL;
                    tos_q <= 4'h0;
                    if (load_w) begin
                        tsh_q <= hold_q;
                        tst_q <= TX_START;
                        td    <= 1'b0;
                    end
                end
                TX_START: if (bend_w) begin
                    tst_q  <= TX_DATA;
                    tbit_q <= 3'h0;
                    td     <= tsh_q[0];
                end
                TX_DATA: if (bend_w) begin
                    tbit_q <= tbit_q + 3'h1;
                    tsh_q  <= tsh_q >> 1;
                    if (tbit_q == 3'h7) begin
                        tst_q <= TX_STOP;
                        td    <= IDLE_LEVEL;
                    end else begin
                        td <= tsh_q[1];
                    end
                end
                TX_STOP: if (bend_w) begin
                    tst_q <= TX_IDLE;
                end
                default: tst_q <= TX_IDLE;
            endcase
        end
    end

    // Handshake outputs and status mirrors.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rts      <= 1'b0;
            dtr      <= 1'b0;
            tx_ready <= 1'b0;
            dsr_seen <= 1'b0;
            dcd_seen <= 1'b0;
            ri_seen  <= 1'b0;
            cts_seen <= 1'b0;
        end else begin
            rts      <= full_q || take_w || (tst_q != TX_IDLE);
            dtr      <= host_ready || ri_w;
            tx_ready <= !full_q && !take_w;
            dsr_seen <= dsr_w;
            dcd_seen <= dcd_w;
            ri_seen  <= ri_w;
            cts_seen <= cts_w;
        end
    end

endmodule // rmc_port

`default_nettype wire

// ==== verif/rmc_port_checker.sv ====
// Timing checks on the ports of the modem control port.
// Assumes binding to every rmc_port instance.
`timescale 1ns/10ps
`default_nettype none

module rmc_port_checker
    import rmc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Host side.
    input wire logic flow_en,
    input wire logic host_ready,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic cts_seen,
    input wire logic dsr_seen,
    // Line pins.
    input wire logic td,
    input wire logic rts,
    input wire logic dtr,
    input wire logic dsr,
    input wire logic ri
);
    // All checks share one clock and reset.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Line relations tied to their causes.
    property p_idle_mark; !rts |-> td; endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("td left mark");
    property p_rts_take; tx_valid && tx_ready |=> rts; endproperty
    a_rts_take: assert property (p_rts_take) else $error("rts late");
    property p_cts_gate; flow_en && !cts_seen && !$past(cts_seen) && $past(td) |-> td; endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("start before cts");
    property p_rts_hold; rts && !td |=> rts; endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("rts dropped mid frame");
    property p_dtr_ring; ri [*8] |-> dtr; endproperty
    a_dtr_ring: assert property (p_dtr_ring) else $error("no dtr on ring");
    property p_dtr_drop; (!host_ready && !ri) [*8] |-> !dtr; endproperty
    a_dtr_drop: assert property (p_dtr_drop) else $error("dtr stuck");
    property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid long");
    property p_dsr_seen; dsr [*6] |-> dsr_seen; endproperty
    a_dsr_seen: assert property (p_dsr_seen) else $error("dsr unseen");

    // Main scenarios reached.
    c_rx: cover property (rx_valid);
    c_wait: cover property (flow_en && rts && !cts_seen);
    c_ring: cover property (ri && !host_ready);
endmodule // rmc_port_checker

bind rmc_port rmc_port_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .flow_en(flow_en), .host_ready(host_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .cts_seen(cts_seen), .dsr_seen(dsr_seen), .td(td), .rts(rts),
    .dtr(dtr), .dsr(dsr), .ri(ri));

`default_nettype wire

// ==== verif/rmc_dce_model.sv ====
// Behavioural modem at the far end: flow control, status and serial data.
// Assumes the bench sets the bit period and calls send for receive traffic.
`timescale 1ns/10ps
`default_nettype none

module rmc_dce_model (
    // Clock and controls from the bench.
    input  wire logic        ref_clk,
    input  wire logic [15:0] bp,
    input  wire logic        hold,
    input  wire logic        carrier,
    input  wire logic        ring,
    // Host lines.
    input  wire logic        td,
    input  wire logic        rts,
    input  wire logic        dtr,
    // Modem lines and capture.
    output logic             rd = 1'b1,
    output logic             cts = 1'b0,
    output logic             dsr = 1'b0,
    output logic             dcd = 1'b0,
    output logic             ri = 1'b0,
    output logic [7:0]       got = 8'h00,
    output int               got_n = 0
);
    // Status answers one clock after its causes: cts and dsr after the host lines, dcd and ri after the bench.
    always @(posedge ref_clk) begin
        cts <= #1 rts && !hold;
        dsr <= #1 dtr;
        dcd <= #1 carrier;
        ri  <= #1 ring;
    end

    // Samples each host character mid bit, LSB first.
    always begin
        @(negedge td);
        repeat (bp / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bp) @(posedge ref_clk);
            got[i] = td;
        end
        repeat (bp) @(posedge ref_clk);
        got_n++;
    end

    // Sends one character; a zero stop bit makes a framing fault.
    task automatic send(input logic [7:0] b, input logic stop_bit);
        logic [9:0] f;
        f = {stop_bit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            rd <= #1 f[i];
            repeat (bp - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rd <= #1 1'b1;
    endtask
endmodule // rmc_dce_model

`default_nettype wire

// ==== verif/rmc_port_tb_top.sv ====
// Self-checking bench for the modem control port.
// Assumes the modem model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module rmc_port_tb_top
    import rmc_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [DIV_W-1:0]  bit_div = 16'h0070;
    logic              flow_en = 1'b0;
    logic              host_ready = 1'b1;
    logic [DATA_W-1:0] tx_data = 8'h00;
    logic              tx_valid = 1'b0;
    logic              hold = 1'b0;
    logic              carrier = 1'b0;
    logic              ring = 1'b0;
    logic [DATA_W-1:0] rx_data, rx_last;
    logic              tx_ready, rx_valid, rx_frame_err, rx_err;
    logic              dsr_seen, dcd_seen, ri_seen, cts_seen;
    logic              td, rd, rts, cts, dtr, dsr, dcd, ri;
    logic [7:0]        got;
    int                got_n, fail_count = 0, checked = 0, cycles = 0, rx_n = 0;

    rmc_port u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bit_div(bit_div),
        .flow_en(flow_en), .host_ready(host_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_frame_err(rx_frame_err), .dsr_seen(dsr_seen), .dcd_seen(dcd_seen),
        .ri_seen(ri_seen), .cts_seen(cts_seen), .td(td), .rd(rd), .rts(rts), .cts(cts),
        .dtr(dtr), .dsr(dsr), .dcd(dcd), .ri(ri));
    rmc_dce_model u_dce (.ref_clk(ref_clk), .bp(bit_div), .hold(hold), .carrier(carrier),
        .ring(ring), .td(td), .rts(rts), .dtr(dtr), .rd(rd), .cts(cts), .dsr(dsr),
        .dcd(dcd), .ri(ri), .got(got), .got_n(got_n));

    // Clock, hang limit and receive capture.
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            rx_last <= rx_data;
            rx_err  <= rx_frame_err;
            rx_n    <= rx_n + 1;
        end
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Offers one character once the holding slot is free.
    task automatic tx_put(input logic [7:0] b);
        int n;
        n = 0;
        while (tx_ready !== 1'b1 && n < 5000) begin
            tick(1);
            n++;
        end
        tx_data  = b;
        tx_valid = 1'b1;
        tick(1);
        tx_valid = 1'b0;
    endtask

    // Waits for the modem to hold n characters, then compares the last.
    task automatic got_is(input int n, input logic [7:0] b);
        for (int i = 0; i < 30000 && got_n < n; i++) tick(1);
        chk(got === b && got_n == n, "tx char wrong");
    endtask

    // Reset values, then the slot opens and terminal-ready follows host_ready one edge on.
    task automatic t_reset();
        chk(td === 1'b1 && rts === 1'b0 && dtr === 1'b0 && tx_ready === 1'b0, "reset");
        tick(1);
        chk(tx_ready === 1'b1 && dtr === 1'b1 && rts === 1'b0, "after reset");
    endtask

    task automatic t_b2b();
        tx_put(8'hA5);
        tx_put(8'h3C);
        got_is(1, 8'hA5);
        got_is(2, 8'h3C);
        tick(150);
        chk(rts === 1'b0 && td === 1'b1, "rts held idle");
    endtask

    task automatic t_flow();
        flow_en = 1'b1;
        hold    = 1'b1;
        tx_put(8'h5A);
        tick(300);
        chk(td === 1'b1 && rts === 1'b1 && tx_ready === 1'b0, "sent without cts");
        hold = 1'b0;
        got_is(3, 8'h5A);
        chk(cts_seen === 1'b1 && rts === 1'b1, "cts not seen");
        tick(150);
        flow_en = 1'b0;
    endtask

    task automatic t_duplex(input logic [7:0] a, input logic [7:0] b, input int n);
        int r0;
        r0 = rx_n;
        fork
            u_dce.send(b, 1'b1);
            tx_put(a);
        join
        got_is(n, a);
        chk(rx_last === b && rx_err === 1'b0 && rx_n == r0 + 1, "rx char wrong");
    endtask

    task automatic t_frame();
        u_dce.send(8'h81, 1'b0);
        tick(1);
        chk(rx_last === 8'h81 && rx_err === 1'b1, "no framing fault");
    endtask

    task automatic t_modem();
        host_ready = 1'b0;
        ring       = 1'b1;
        tick(20);
        chk(dtr === 1'b1 && ri_seen === 1'b1 && dsr_seen === 1'b1, "ring");
        ring    = 1'b0;
        carrier = 1'b1;
        tick(20);
        chk(dtr === 1'b0 && dsr_seen === 1'b0 && dcd_seen === 1'b1, "idle");
        chk(ri_seen === 1'b0, "ring stuck");
        host_ready = 1'b1;
        tick(20);
        chk(dtr === 1'b1 && cts_seen === 1'b0, "host ready");
    endtask

    // A divider below the fastest rate is held at 100 cycles, so the start bit stays near it.
    task automatic t_clamp();
        int n;
        n = 0;
        bit_div = 16'h0040;
        tx_put(8'hFF);
        while (td !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        n = 0;
        while (td === 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        chk(n >= 88 && n <= 100, "rate not clamped");
    endtask

    // Main sequence: reset for four cycles, then each scenario.
    initial begin
        tick(4);
        sys_rst = 1'b0;
        t_reset();
        t_b2b();
        t_flow();
        t_duplex(8'h96, 8'hC3, 4);
        t_frame();
        bit_div = 16'h00D0;
        t_duplex(8'hE7, 8'h4B, 5);
        t_modem();
        t_clamp();
        end_of_test();
    end
endmodule // rmc_port_tb_top

`default_nettype wire
